// ===== src/nvm_pkg.sv
package nvm_pkg;

   // ==========================================================
   // register indices (byte address = index * 4)
   // ==========================================================
   localparam logic [7:0] IDX_OTP_PROGRAM = 8'h2B;
   localparam logic [7:0] IDX_REGION_LOCK = 8'h35;
   localparam logic [7:0] IDX_MAP_INIT_TWO = 8'h3D;
   localparam logic [7:0] IDX_SETUP_WORD = 8'h3F;

   // ==========================================================
   // otp_program_register fields
   // ==========================================================
   localparam int OTP_MULTI_BIT = 7;
   localparam int OTP_LATCH_BIT = 5;
   localparam int OTP_COLUMN_BIT = 4;
   localparam int OTP_ROW_BIT = 3;
   localparam int OTP_BURN_BIT = 0;
   localparam logic [7:0] OTP_RESET = 8'h00;

   // ==========================================================
   // region_lock_register fields
   // ==========================================================
   localparam int LOCK_MASS_BIT = 7;
   localparam int LOCK_REGION4_BIT = 5;
   localparam int LOCK_SETUP_BIT = 4;
   localparam logic [7:0] LOCK_RESET = 8'hBF;
   localparam logic [7:0] LOCK_IMPL_MASK = 8'hBF;

   // ==========================================================
   // map, setup word, timing
   // ==========================================================
   localparam logic [3:0] MAP_PAGE_RESET = 4'h0;
   localparam int SETUP_ENABLE_BIT = 0;
   localparam logic [7:0] SETUP_RESET = 8'h01;
   localparam int PROTECT_WINDOW_CYC = 64;

   // ==========================================================
   // eeprom geometry (offsets inside the 4K page)
   // ==========================================================
   localparam logic [11:0] EE_BASE_OFF = 12'hD00;
   localparam int EE_BYTES = 768;
   localparam int EE_ROW_BYTES = 16;
   localparam logic [7:0] EE_SPARE_ROW_HI = 8'hCF;
   localparam logic [9:0] EE_SPARE_IDX = 10'h300;
   localparam logic [9:0] EE_LAST_IDX = 10'h2FF;
   localparam int EE_DEPTH = 784;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [11:0] REGION_LAST [5] = '{12'hD1F, 12'hD5F, 12'hDDF, 12'hEFF, 12'hFFF};

   // ==========================================================
   // otp multi-byte burn: ignored address bits 15, 14, 7, 4
   // ==========================================================
   localparam logic [15:0] OTP_MULTI_IGNORE = 16'hC090;
   localparam logic [15:0] OTP_BASE_ADDR = 16'h4000;
   localparam logic [4:0] OTP_COLUMN_LOW = 5'h1F;

   typedef enum logic [1:0] {
      CMD_PROGRAM,
      CMD_BYTE_ERASE,
      CMD_ROW_ERASE,
      CMD_BULK_ERASE
   } ee_cmd_e;

   typedef enum logic [0:0] {
      ST_IDLE,
      ST_SWEEP
   } sweep_e;

   typedef struct packed {
      logic valid;
      ee_cmd_e kind;
      logic to_setup;
      logic [15:0] addr;
      logic [7:0] data;
   } ee_cmd_s;

endpackage

// ===== src/nvm_byte_ram.sv
`timescale 1ns/10ps
module nvm_byte_ram #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 784,
   parameter int AW = 10
) (
   input wire logic clk_sys_i,
   input wire logic ce_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic rd_en_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);
   // cells are nonvolatile, so they take no reset
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_sys_i) begin
      if (ce_i) begin
         if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
         end
         if (rd_en_i) begin
            rd_data_o <= mem[rd_addr_i];
         end
      end
   end
endmodule // nvm_byte_ram

// ===== src/nvm_program_protect.sv
// Local design decision: the APB slave port.
`timescale 1ns/10ps
module nvm_program_protect #(
   parameter logic [15:0] OTP_BASE = nvm_pkg::OTP_BASE_ADDR
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic special_mode_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire nvm_pkg::ee_cmd_s cmd_i,
   output logic cmd_ready_o,
   output logic cmd_done_o,
   input wire logic mem_rd_i,
   input wire logic mem_wr_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic [7:0] mem_wdata_i,
   output logic mem_rvalid_o,
   output logic mem_hit_o,
   output logic [7:0] mem_rdata_o,
   output logic eeprom_present_o,
   output logic otp_latch_enable_o,
   output logic burn_voltage_on_o,
   output logic spare_column_select_o,
   output logic spare_row_select_o,
   output logic [15:0] otp_addr_o,
   output logic [7:0] otp_data_o,
   output logic [15:0] otp_addr_ignore_o
);

   typedef struct packed {
      logic multi_byte_burn;
      logic otp_latch_enable;
      logic spare_column_select;
      logic spare_row_select;
      logic burn_voltage_on;
      logic [7:0] locks;
      logic [3:0] page;
      logic [7:0] setup;
      logic [6:0] win_cnt;
      logic clr_used;
      logic pready;
      logic pslverr;
      logic [7:0] prdata;
      nvm_pkg::sweep_e fsm;
      logic [9:0] cur;
      logic [9:0] last;
      logic ready;
      logic done;
      logic rd_pend;
      logic rd_hit;
      logic rvalid;
      logic hit;
      logic [7:0] rdata;
      logic [15:0] otp_addr;
      logic [7:0] otp_data;
      logic [15:0] ignore;
   } state_s;

   localparam logic [6:0] WINDOW_CYC = 7'(nvm_pkg::PROTECT_WINDOW_CYC);

   state_s s_r;
   state_s s_nxt;
   logic ram_we;
   logic [9:0] ram_waddr;
   logic [7:0] ram_wdata;
   logic ram_re;
   logic [9:0] ram_raddr;
   logic [7:0] ram_q;
   logic [10:0] rd_loc;
   logic [10:0] cmd_loc;
   logic cmd_ok;
   logic [7:0] wbyte;
   logic apb_access;
   logic [7:0] otp_view;

   // ==========================================================
   // decode helpers
   // ==========================================================
   function automatic logic [11:0] reg_byte_addr(input logic [7:0] idx);
      reg_byte_addr = {2'b00, idx, 2'b00};
   endfunction

   // {hit, index}: array window or spare row of the mapped page
   function automatic logic [10:0] ee_locate(input logic [15:0] a, input logic [3:0] page,
                                             input logic special, input logic enable);
      ee_locate = 11'h000;
      if (enable && a[15:12] == page) begin
         if (a[11:0] >= nvm_pkg::EE_BASE_OFF) begin
            ee_locate = {1'b1, 10'(a[11:0] - nvm_pkg::EE_BASE_OFF)};
         end else if (special && a[11:4] == nvm_pkg::EE_SPARE_ROW_HI) begin
            ee_locate = {1'b1, nvm_pkg::EE_SPARE_IDX | {6'h00, a[3:0]}};
         end
      end
   endfunction

   // lock bits of the register reordered to region 0..4
   function automatic logic [4:0] region_bits(input logic [7:0] locks);
      region_bits = {locks[nvm_pkg::LOCK_REGION4_BIT], locks[3:0]};
   endfunction

   function automatic logic region_locked(input logic [11:0] off, input logic [7:0] locks);
      logic [4:0] rb;
      logic found;
      rb = region_bits(locks);
      found = 1'b0;
      region_locked = 1'b0;
      for (int i = 0; i < 5; i++) begin
         if (!found && off >= nvm_pkg::EE_BASE_OFF && off <= nvm_pkg::REGION_LAST[i]) begin
            found = 1'b1;
            region_locked = rb[i];
         end
      end
   endfunction

   assign apb_access = psel_i && penable_i;
   assign wbyte = pwdata_i[7:0];
   assign rd_loc = ee_locate(mem_addr_i, s_r.page, special_mode_i, s_r.setup[nvm_pkg::SETUP_ENABLE_BIT]);
   assign cmd_loc = ee_locate(cmd_i.addr, s_r.page, special_mode_i, s_r.setup[nvm_pkg::SETUP_ENABLE_BIT]);

   // ==========================================================
   // permission for eeprom and setup-word operations
   // ==========================================================
   always_comb begin
      cmd_ok = 1'b0;
      if (cmd_i.to_setup) begin
         cmd_ok = special_mode_i || !s_r.locks[nvm_pkg::LOCK_SETUP_BIT];
      end else if (cmd_loc[10]) begin
         unique case (cmd_i.kind)
            nvm_pkg::CMD_PROGRAM, nvm_pkg::CMD_BYTE_ERASE: begin
               cmd_ok = cmd_loc[9:0] >= nvm_pkg::EE_SPARE_IDX || !region_locked(cmd_i.addr[11:0], s_r.locks);
            end
            nvm_pkg::CMD_ROW_ERASE: begin
               cmd_ok = !s_r.locks[nvm_pkg::LOCK_MASS_BIT] &&
                  (cmd_loc[9:0] >= nvm_pkg::EE_SPARE_IDX || !region_locked(cmd_i.addr[11:0], s_r.locks));
            end
            nvm_pkg::CMD_BULK_ERASE: begin
               cmd_ok = !s_r.locks[nvm_pkg::LOCK_MASS_BIT] && region_bits(s_r.locks) == 5'h00;
            end
         endcase
      end
   end

   // special-only bits read zero in normal modes
   assign otp_view = {s_r.multi_byte_burn && special_mode_i, 1'b0, s_r.otp_latch_enable,
                      s_r.spare_column_select && special_mode_i, s_r.spare_row_select && special_mode_i,
                      2'b00, s_r.burn_voltage_on};

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      s_nxt = s_r;
      ram_we = 1'b0;
      ram_waddr = s_r.cur;
      ram_wdata = nvm_pkg::ERASED_BYTE;
      ram_re = 1'b0;
      ram_raddr = rd_loc[9:0];
      s_nxt.done = 1'b0;
      s_nxt.rvalid = 1'b0;

      if (s_r.win_cnt != WINDOW_CYC) begin
         s_nxt.win_cnt = s_r.win_cnt + 7'h01;
      end

      // register bus: pready rises one cycle into the access phase
      if (apb_access && !s_r.pready) begin
         s_nxt.pready = 1'b1;
         s_nxt.pslverr = 1'b1;
         s_nxt.prdata = 8'h00;
         if (paddr_i == reg_byte_addr(nvm_pkg::IDX_OTP_PROGRAM)) begin
            s_nxt.prdata = otp_view;
            s_nxt.pslverr = 1'b0;
         end else if (paddr_i == reg_byte_addr(nvm_pkg::IDX_REGION_LOCK)) begin
            s_nxt.prdata = s_r.locks & nvm_pkg::LOCK_IMPL_MASK;
            s_nxt.pslverr = 1'b0;
         end else if (paddr_i == reg_byte_addr(nvm_pkg::IDX_MAP_INIT_TWO)) begin
            s_nxt.prdata = {s_r.page, 4'h0};
            s_nxt.pslverr = 1'b0;
         end else if (paddr_i == reg_byte_addr(nvm_pkg::IDX_SETUP_WORD)) begin
            s_nxt.prdata = s_r.setup;
            s_nxt.pslverr = 1'b0;
         end
      end else if (apb_access && s_r.pready) begin
         s_nxt.pready = 1'b0;
         s_nxt.pslverr = 1'b0;
         if (pwrite_i && !s_r.pslverr) begin
            if (paddr_i == reg_byte_addr(nvm_pkg::IDX_OTP_PROGRAM)) begin
               s_nxt.otp_latch_enable = wbyte[nvm_pkg::OTP_LATCH_BIT];
               s_nxt.multi_byte_burn = wbyte[nvm_pkg::OTP_MULTI_BIT] && special_mode_i;
               s_nxt.spare_column_select = wbyte[nvm_pkg::OTP_COLUMN_BIT] && special_mode_i;
               s_nxt.spare_row_select = wbyte[nvm_pkg::OTP_ROW_BIT] && special_mode_i;
               if (s_r.otp_latch_enable) begin
                  s_nxt.burn_voltage_on = wbyte[nvm_pkg::OTP_BURN_BIT];
               end
               if (!wbyte[nvm_pkg::OTP_LATCH_BIT]) begin
                  s_nxt.burn_voltage_on = 1'b0;
               end
            end else if (paddr_i == reg_byte_addr(nvm_pkg::IDX_REGION_LOCK)) begin
               // special mode clears any time; otherwise one clear inside window; sets any time
               if (special_mode_i || (s_r.win_cnt != WINDOW_CYC && !s_r.clr_used)) begin
                  s_nxt.locks = wbyte & nvm_pkg::LOCK_IMPL_MASK;
                  s_nxt.clr_used = !special_mode_i;
               end else begin
                  s_nxt.locks = (s_r.locks | wbyte) & nvm_pkg::LOCK_IMPL_MASK;
               end
            end else if (paddr_i == reg_byte_addr(nvm_pkg::IDX_MAP_INIT_TWO)) begin
               s_nxt.page = wbyte[7:4];
            end else if (paddr_i == reg_byte_addr(nvm_pkg::IDX_SETUP_WORD)) begin
               if (special_mode_i || !s_r.locks[nvm_pkg::LOCK_SETUP_BIT]) begin
                  s_nxt.setup = wbyte;
               end
            end
         end
      end else begin
         s_nxt.pready = 1'b0;
         s_nxt.pslverr = 1'b0;
      end

      // special-only bits drop in normal modes
      if (!special_mode_i) begin
         s_nxt.multi_byte_burn = 1'b0;
         s_nxt.spare_column_select = 1'b0;
         s_nxt.spare_row_select = 1'b0;
      end

      s_nxt.ignore = s_nxt.multi_byte_burn ? nvm_pkg::OTP_MULTI_IGNORE : 16'h0000;

      if (mem_wr_i && s_r.otp_latch_enable && mem_addr_i >= OTP_BASE) begin
         if ((!s_r.spare_column_select || mem_addr_i[4:0] == nvm_pkg::OTP_COLUMN_LOW) &&
             (!s_r.spare_row_select || mem_addr_i[11:7] == 5'h00)) begin
            s_nxt.otp_addr = mem_addr_i;
            s_nxt.otp_data = mem_wdata_i;
         end
      end

      // eeprom read: ram register, then output register
      ram_re = mem_rd_i && rd_loc[10];
      s_nxt.rd_pend = mem_rd_i;
      s_nxt.rd_hit = rd_loc[10];
      if (s_r.rd_pend) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.hit = s_r.rd_hit;
         // unmapped reads float high like erased cells
         s_nxt.rdata = s_r.rd_hit ? ram_q : nvm_pkg::ERASED_BYTE;
      end

      unique case (s_r.fsm)
         nvm_pkg::ST_IDLE: begin
            if (cmd_i.valid) begin
               s_nxt.done = 1'b1;
               if (cmd_ok && cmd_i.to_setup) begin
                  s_nxt.setup = cmd_i.kind == nvm_pkg::CMD_PROGRAM ? cmd_i.data : nvm_pkg::ERASED_BYTE;
               end else if (cmd_ok) begin
                  unique case (cmd_i.kind)
                     nvm_pkg::CMD_PROGRAM: begin
                        ram_we = 1'b1;
                        ram_waddr = cmd_loc[9:0];
                        ram_wdata = cmd_i.data;
                     end
                     nvm_pkg::CMD_BYTE_ERASE: begin
                        ram_we = 1'b1;
                        ram_waddr = cmd_loc[9:0];
                     end
                     nvm_pkg::CMD_ROW_ERASE: begin
                        s_nxt.done = 1'b0;
                        s_nxt.ready = 1'b0;
                        s_nxt.fsm = nvm_pkg::ST_SWEEP;
                        s_nxt.cur = {cmd_loc[9:4], 4'h0};
                        s_nxt.last = {cmd_loc[9:4], 4'hF};
                     end
                     nvm_pkg::CMD_BULK_ERASE: begin
                        s_nxt.done = 1'b0;
                        s_nxt.ready = 1'b0;
                        s_nxt.fsm = nvm_pkg::ST_SWEEP;
                        s_nxt.cur = 10'h000;
                        s_nxt.last = nvm_pkg::EE_LAST_IDX;
                     end
                  endcase
               end
            end
         end
         nvm_pkg::ST_SWEEP: begin
            // sweep one byte per cycle to all ones
            ram_we = 1'b1;
            ram_waddr = s_r.cur;
            s_nxt.cur = s_r.cur + 10'h001;
            if (s_r.cur == s_r.last) begin
               s_nxt.fsm = nvm_pkg::ST_IDLE;
               s_nxt.ready = 1'b1;
               s_nxt.done = 1'b1;
            end
         end
      endcase
   end

   // ==========================================================
   // state register
   // ==========================================================
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.multi_byte_burn <= nvm_pkg::OTP_RESET[nvm_pkg::OTP_MULTI_BIT];
         s_r.otp_latch_enable <= nvm_pkg::OTP_RESET[nvm_pkg::OTP_LATCH_BIT];
         s_r.spare_column_select <= nvm_pkg::OTP_RESET[nvm_pkg::OTP_COLUMN_BIT];
         s_r.spare_row_select <= nvm_pkg::OTP_RESET[nvm_pkg::OTP_ROW_BIT];
         s_r.burn_voltage_on <= nvm_pkg::OTP_RESET[nvm_pkg::OTP_BURN_BIT];
         s_r.locks <= nvm_pkg::LOCK_RESET;
         s_r.page <= nvm_pkg::MAP_PAGE_RESET;
         s_r.setup <= nvm_pkg::SETUP_RESET;
         s_r.fsm <= nvm_pkg::ST_IDLE;
         s_r.ready <= 1'b1;
         s_r.rdata <= nvm_pkg::ERASED_BYTE;
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   nvm_byte_ram #(
      .WIDTH(8),
      .DEPTH(nvm_pkg::EE_DEPTH),
      .AW(10)
   ) u_ram (
      .clk_sys_i(clk_sys_i),
      .ce_i(ce_i),
      .wr_en_i(ram_we),
      .wr_addr_i(ram_waddr),
      .wr_data_i(ram_wdata),
      .rd_en_i(ram_re),
      .rd_addr_i(ram_raddr),
      .rd_data_o(ram_q)
   );

   // ==========================================================
   // outputs
   // ==========================================================
   assign prdata_o = {24'h000000, s_r.prdata};
   assign pready_o = s_r.pready;
   assign pslverr_o = s_r.pslverr;
   assign cmd_ready_o = s_r.ready;
   assign cmd_done_o = s_r.done;
   assign mem_rvalid_o = s_r.rvalid;
   assign mem_hit_o = s_r.hit;
   assign mem_rdata_o = s_r.rdata;
   assign eeprom_present_o = s_r.setup[nvm_pkg::SETUP_ENABLE_BIT];
   assign otp_latch_enable_o = s_r.otp_latch_enable;
   assign burn_voltage_on_o = s_r.burn_voltage_on;
   assign spare_column_select_o = s_r.spare_column_select;
   assign spare_row_select_o = s_r.spare_row_select;
   assign otp_addr_o = s_r.otp_addr;
   assign otp_data_o = s_r.otp_data;
   assign otp_addr_ignore_o = s_r.ignore;

endmodule // nvm_program_protect

// ===== verif/nvm_program_protect_asserts.sv
`timescale 1ns/10ps
// ==========================================================
// port-level checks
module nvm_program_protect_asserts #(
   parameter logic [15:0] OTP_BASE = nvm_pkg::OTP_BASE_ADDR
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire nvm_pkg::ee_cmd_s cmd_i,
   input wire logic cmd_ready_o,
   input wire logic cmd_done_o,
   input wire logic mem_rd_i,
   input wire logic mem_wr_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic [7:0] mem_wdata_i,
   input wire logic mem_rvalid_o,
   input wire logic mem_hit_o,
   input wire logic [7:0] mem_rdata_o,
   input wire logic otp_latch_enable_o,
   input wire logic burn_voltage_on_o,
   input wire logic spare_column_select_o,
   input wire logic spare_row_select_o,
   input wire logic [15:0] otp_addr_o,
   input wire logic [7:0] otp_data_o,
   input wire logic [15:0] otp_addr_ignore_o
);
   localparam logic [11:0] LOCK_ADDR = {2'b00, nvm_pkg::IDX_REGION_LOCK, 2'b00};
   localparam logic [11:0] OTP_ADDR = {2'b00, nvm_pkg::IDX_OTP_PROGRAM, 2'b00};
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   sequence s_access;
      psel_i && penable_i && !pready_o;
   endsequence
   sequence s_answer;
      pready_o ##1 !pready_o;
   endsequence
   a_apb_answer: assert property (s_access |=> s_answer)
      else $error("apb answer not a single cycle pulse after access");
   a_err_ready: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
      else $error("error response outside an answered access");
   a_rdata_upper: assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
      else $error("upper read data lanes not zero");
   a_lock_bit6: assert property (pready_o && !pwrite_i && paddr_i == LOCK_ADDR |-> !prdata_o[6])
      else $error("lock register bit 6 read as one");
   a_burn_latched: assert property (burn_voltage_on_o |-> otp_latch_enable_o)
      else $error("burn voltage on while latch clear");
   a_burn_rise: assert property ($rose(burn_voltage_on_o) |-> $past(pready_o && pwrite_i && paddr_i == OTP_ADDR && pwdata_i[0]))
      else $error("burn voltage rose without a burn write");
   a_ignore_value: assert property (otp_addr_ignore_o != 16'h0000 |-> otp_addr_ignore_o == nvm_pkg::OTP_MULTI_IGNORE)
      else $error("multi-byte ignore mask wrong");
   a_read_latency: assert property (mem_rd_i |-> ##2 mem_rvalid_o)
      else $error("memory read answer late");
   a_miss_erased: assert property (mem_rvalid_o && !mem_hit_o |-> mem_rdata_o == nvm_pkg::ERASED_BYTE)
      else $error("missed read not all ones");
   a_cmd_done: assert property (cmd_i.valid && cmd_ready_o && cmd_i.kind == nvm_pkg::CMD_PROGRAM |=> cmd_done_o)
      else $error("program command not answered next cycle");
   a_otp_capture: assert property (mem_wr_i && otp_latch_enable_o && mem_addr_i >= OTP_BASE && !spare_column_select_o
         && !spare_row_select_o && otp_addr_ignore_o == 16'h0000 |=> otp_addr_o == $past(mem_addr_i)
         && otp_data_o == $past(mem_wdata_i))
      else $error("otp write not captured");
endmodule // nvm_program_protect_asserts

bind nvm_program_protect nvm_program_protect_asserts #(.OTP_BASE(OTP_BASE)) chk_u (
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .cmd_done_o(cmd_done_o), .mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i),
   .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i), .mem_rvalid_o(mem_rvalid_o), .mem_hit_o(mem_hit_o),
   .mem_rdata_o(mem_rdata_o), .otp_latch_enable_o(otp_latch_enable_o), .burn_voltage_on_o(burn_voltage_on_o),
   .spare_column_select_o(spare_column_select_o), .spare_row_select_o(spare_row_select_o),
   .otp_addr_o(otp_addr_o), .otp_data_o(otp_data_o), .otp_addr_ignore_o(otp_addr_ignore_o)
);

// ===== verif/nvm_program_protect_tb.sv
`timescale 1ns/10ps
module nvm_program_protect_tb;
   localparam logic [7:0] LOCK = nvm_pkg::IDX_REGION_LOCK;
   localparam logic [7:0] OTP = nvm_pkg::IDX_OTP_PROGRAM;
   localparam logic [7:0] MAP = nvm_pkg::IDX_MAP_INIT_TWO;
   localparam logic [7:0] SETUP = nvm_pkg::IDX_SETUP_WORD;
   logic clk_sys_i, rst_i, special, psel, penable, pwrite, pready, pslverr, err_q;
   logic cmd_ready, cmd_done, mem_rd, mem_wr, mem_rvalid, mem_hit, present, latch, burn, col, row;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_q;
   logic [15:0] mem_addr, otp_addr, ignore;
   logic [7:0] mem_wdata, mem_rdata, otp_data;
   nvm_pkg::ee_cmd_s cmd;
   int mismatches = 0;
   int tests_run = 0;
   int cyc = 0;

   // ce held high: freezing is not exercised here
   nvm_program_protect dut_u (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1), .special_mode_i(special), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .cmd_i(cmd), .cmd_ready_o(cmd_ready), .cmd_done_o(cmd_done),
      .mem_rd_i(mem_rd), .mem_wr_i(mem_wr), .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata),
      .mem_rvalid_o(mem_rvalid), .mem_hit_o(mem_hit), .mem_rdata_o(mem_rdata), .eeprom_present_o(present),
      .otp_latch_enable_o(latch), .burn_voltage_on_o(burn), .spare_column_select_o(col), .spare_row_select_o(row),
      .otp_addr_o(otp_addr), .otp_data_o(otp_data), .otp_addr_ignore_o(ignore)
   );

   // ==========================================================
   // helpers
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk_sys_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do @(posedge clk_sys_i); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      chk(rd_q, {24'h000000, e});
   endtask

   task automatic mrd(input logic [15:0] a, input logic h, input logic [7:0] d);
      @(posedge clk_sys_i);
      mem_rd <= 1'b1;
      mem_addr <= a;
      @(posedge clk_sys_i);
      mem_rd <= 1'b0;
      do @(posedge clk_sys_i); while (mem_rvalid !== 1'b1);
      chk({23'h000000, mem_hit, mem_rdata}, {23'h000000, h, d});
   endtask

   task automatic ee(input nvm_pkg::ee_cmd_e k, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      cmd <= '{valid: 1'b1, kind: k, to_setup: 1'b0, addr: a, data: d};
      do @(posedge clk_sys_i); while (cmd_ready !== 1'b1);
      cmd.valid <= 1'b0;
      do @(posedge clk_sys_i); while (cmd_done !== 1'b1);
   endtask

   // ==========================================================
   // clock, watchdog, sequence
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   // about 220 cycles expected; generous margin
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         conclude();
      end
   end

   initial begin
      {psel, penable, pwrite, mem_rd, mem_wr, special} = '0;
      {paddr, pwdata, mem_addr, mem_wdata} = '0;
      cmd = '0;
      rst_i = 1'b1;
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd(LOCK, 8'hBF);
      rd(OTP, 8'h00);
      rd(SETUP, 8'h01);
      wr(LOCK, 8'h00);
      rd(LOCK, 8'h00);
      chk({31'h0, present}, 32'h1);
      apb(1'b0, 8'h00, 8'h00);
      chk({31'h0, err_q}, 32'h1);
      ee(nvm_pkg::CMD_PROGRAM, 16'h0D00, 8'h5A);
      mrd(16'h0D00, 1'b1, 8'h5A);
      ee(nvm_pkg::CMD_BYTE_ERASE, 16'h0D00, 8'h00);
      mrd(16'h0D00, 1'b1, 8'hFF);
      wr(LOCK, 8'h40);
      rd(LOCK, 8'h00);
      wr(LOCK, 8'h01);
      ee(nvm_pkg::CMD_PROGRAM, 16'h0D00, 8'h11);
      mrd(16'h0D00, 1'b1, 8'hFF);
      ee(nvm_pkg::CMD_PROGRAM, 16'h0D20, 8'h22);
      mrd(16'h0D20, 1'b1, 8'h22);
      wr(LOCK, 8'h80);
      ee(nvm_pkg::CMD_BULK_ERASE, 16'h0D20, 8'h00);
      mrd(16'h0D20, 1'b1, 8'h22);
      wr(LOCK, 8'h00);
      rd(LOCK, 8'h81);
      wr(LOCK, 8'h10);
      wr(SETUP, 8'h00);
      rd(SETUP, 8'h01);
      special <= 1'b1;
      wr(SETUP, 8'h00);
      rd(SETUP, 8'h00);
      chk({31'h0, present}, 32'h0);
      mrd(16'h0D20, 1'b0, 8'hFF);
      wr(SETUP, 8'h01);
      wr(MAP, 8'h20);
      mrd(16'h2D20, 1'b1, 8'h22);
      mrd(16'h0D20, 1'b0, 8'hFF);
      wr(LOCK, 8'h00);
      rd(LOCK, 8'h00);
      ee(nvm_pkg::CMD_ROW_ERASE, 16'h2D20, 8'h00);
      mrd(16'h2D20, 1'b1, 8'hFF);
      ee(nvm_pkg::CMD_PROGRAM, 16'h2CF0, 8'h3C);
      mrd(16'h2CF0, 1'b1, 8'h3C);
      wr(OTP, 8'h01);
      rd(OTP, 8'h00);
      wr(OTP, 8'h20);
      wr(OTP, 8'h21);
      rd(OTP, 8'h21);
      chk({30'h0, latch, burn}, 32'h3);
      @(posedge clk_sys_i);
      mem_wr <= 1'b1;
      mem_addr <= 16'h4026;
      mem_wdata <= 8'h77;
      @(posedge clk_sys_i);
      mem_wr <= 1'b0;
      @(posedge clk_sys_i);
      chk({8'h00, otp_addr, otp_data}, 32'h00402677);
      wr(OTP, 8'h00);
      rd(OTP, 8'h00);
      chk({30'h0, latch, burn}, 32'h0);
      wr(OTP, 8'h98);
      rd(OTP, 8'h98);
      chk({16'h0000, ignore}, 32'h0000C090);
      chk({30'h0, col, row}, 32'h3);
      special <= 1'b0;
      rd(OTP, 8'h00);
      chk({30'h0, col, row}, 32'h0);
      chk({16'h0000, ignore}, 32'h00000000);
      mrd(16'h2CF0, 1'b0, 8'hFF);
      conclude();
   end
endmodule // nvm_program_protect_tb
